//--- rtl/micro_edge_pwm_config.sv
// Summary of operation
// - config bit 3 picks fine shadow load: zero or period
// - load selection applies only in duty control mode
// - bit 2 picks fine compare (0) or fine phase (1) source
// - bits 1-0: off, rising, falling, both edges
// - fine compare in bits 15-8; nonzero step enables fine edge
// - config writes ignored unless protected window is open
// - fine compare at 0x8, coarse at 0x9, config at 0x20
// - fine phase in bits 15-8, low byte reads zero
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module micro_edge_pwm_config
  import micro_edge_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk, // 50 MHz time-base clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [9:0] address, // byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte enables
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait request
  output logic [1:0] response, // 00 okay, 10 slave error
  output logic pwmOut, // coarse-timed channel output
  output logic [7:0] riseStep, // micro-edge step on rising edge
  output logic [7:0] fallStep // micro-edge step on falling edge
);
  logic [15:0] tbControl, next_tbControl;
  logic [15:0] tbPhase, next_tbPhase;
  logic [15:0] tbPeriod, next_tbPeriod;
  logic [15:0] compareControl, next_compareControl;
  logic [15:0] coarseShadow, next_coarseShadow;
  logic [15:0] coarseActive, next_coarseActive;
  logic [15:0] coarseB, next_coarseB;
  logic [7:0] fineShadow, next_fineShadow;
  logic [7:0] fineActive, next_fineActive;
  logic [7:0] finePhase, next_finePhase;
  logic [3:0] highResConfig, next_highResConfig;
  logic protectOpen, next_protectOpen;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [1:0] next_response;
  logic pending, next_pending;
  logic sawZero, next_sawZero;
  logic sawPeriod, next_sawPeriod;

  logic [WIDTH-1:0] count;
  logic atZero;
  logic atPeriod;
  logic counterWrite;
  logic [7:0] wordIdx;
  logic [15:0] wdata;
  logic fineLoadEvent;
  logic coarseLoadEvent;
  logic [7:0] fineSel;
  logic [1:0] edgeMode;
  logic fineInUse;

  // merges a write with byte enables into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [3:0] be);
    merge = old;
    if (be[0])
      merge[7:0] = val[7:0];
    if (be[1])
      merge[15:8] = val[15:8];
  endfunction

  // 32-bit word address
  assign wordIdx = address[9:2];
  assign wdata = writedata[15:0];
  // counter write lands at the answer edge, while the request still stands;
  // pending has already dropped there, so it must not qualify the load
  assign counterWrite = write && !waitrequest
    && wordIdx == IDX_TB_COUNTER;

  time_base_counter #(
    .WIDTH(WIDTH)
  ) counterInst (
    .clk(clk),
    .rst_n(rst_n),
    .run(tbControl[CTRMODE_LSB +: 2] != 2'b11),
    .period(tbPeriod),
    .loadCount(counterWrite),
    .loadValue(wdata),
    .count(count),
    .atZero(atZero),
    .atPeriod(atPeriod)
  );

  assign fineLoadEvent = highResConfig[CFG_LOAD_SEL_BIT] ? atPeriod : atZero;

  always_comb
  begin
    case (coarse_load_t'(compareControl[COARSE_LOAD_MODE_LSB +: 2]))
      CLOAD_ZERO: coarseLoadEvent = atZero;
      CLOAD_PERIOD: coarseLoadEvent = atPeriod;
      CLOAD_EITHER: coarseLoadEvent = atZero || atPeriod;
      // freeze keeps the active compare as it is
      CLOAD_FREEZE: coarseLoadEvent = 1'b0;
      default: coarseLoadEvent = 1'b0;
    endcase
  end

  assign fineSel = highResConfig[CFG_SOURCE_BIT] ? finePhase : fineActive;

  assign edgeMode = highResConfig[CFG_EDGE_LSB +: 2];
  // a zero fine step leaves the edge coarse
  assign fineInUse = (fineSel != 8'h00) && edgeMode != EDGE_OFF;

  always_comb
  begin
    next_tbControl = tbControl;
    next_tbPhase = tbPhase;
    next_tbPeriod = tbPeriod;
    next_compareControl = compareControl;
    next_coarseShadow = coarseShadow;
    next_coarseActive = coarseActive;
    next_coarseB = coarseB;
    next_fineShadow = fineShadow;
    next_fineActive = fineActive;
    next_finePhase = finePhase;
    next_highResConfig = highResConfig;
    next_protectOpen = protectOpen;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    next_response = response;
    next_pending = pending;
    next_sawZero = sawZero | atZero;
    next_sawPeriod = sawPeriod | atPeriod;

    if (coarseLoadEvent)
      next_coarseActive = coarseShadow;
    if (!highResConfig[CFG_SOURCE_BIT] && fineLoadEvent)
      next_fineActive = fineShadow;

    if ((read || write) && !pending && waitrequest)
      next_pending = 1'b1;

    if (pending && waitrequest)
    begin
      next_waitrequest = 1'b0;
      next_pending = 1'b0;
      next_response = 2'b00;
      next_readdata = 32'h00000000;
      case (wordIdx)
        IDX_TB_CONTROL:
          if (write)
            next_tbControl = merge(tbControl, wdata, byteenable);
          else
            next_readdata[15:0] = tbControl;
        IDX_TB_STATUS:
          if (read)
            next_readdata[1:0] = {sawPeriod, sawZero};
          else
          begin
            // write one clears; a new event wins
            if (byteenable[0] && wdata[0])
              next_sawZero = atZero;
            if (byteenable[0] && wdata[1])
              next_sawPeriod = atPeriod;
          end
        IDX_FINE_PHASE:
          if (write && byteenable[1])
            next_finePhase = wdata[15:8];
          else if (read)
            next_readdata[15:8] = finePhase;
        IDX_TB_PHASE:
          if (write)
            next_tbPhase = merge(tbPhase, wdata, byteenable);
          else
            next_readdata[15:0] = tbPhase;
        IDX_TB_COUNTER:
          if (read)
            next_readdata[15:0] = count;
        IDX_TB_PERIOD:
          if (write)
            next_tbPeriod = merge(tbPeriod, wdata, byteenable);
          else
            next_readdata[15:0] = tbPeriod;
        IDX_COMPARE_CONTROL:
          if (write)
            next_compareControl = merge(compareControl, wdata, byteenable);
          else
            next_readdata[15:0] = compareControl;
        IDX_FINE_COMPARE_A:
          if (write && byteenable[1])
            next_fineShadow = wdata[FINE_LSB +: 8];
          else if (read)
            next_readdata[15:8] = fineShadow;
        IDX_COARSE_COMPARE_A:
          if (write)
            next_coarseShadow = merge(coarseShadow, wdata, byteenable);
          else
            next_readdata[15:0] = coarseShadow;
        IDX_COARSE_COMPARE_B:
          if (write)
            next_coarseB = merge(coarseB, wdata, byteenable);
          else
            next_readdata[15:0] = coarseB;
        IDX_HIGH_RES_CONFIG:
          if (write)
          begin
            if (protectOpen && byteenable[0])
              next_highResConfig = wdata[3:0] & CFG_WRITE_MASK[3:0];
          end
          else
            next_readdata[3:0] = highResConfig;
        IDX_PROTECT:
          if (write && byteenable[0])
            next_protectOpen = wdata[0];
          else if (read)
            next_readdata[0] = protectOpen;
        IDX_ACTIVE_STATUS:
          if (read)
          begin
            next_readdata[15:8] = fineActive;
            next_readdata[0] = fineInUse;
          end
        default:
          next_response = 2'b10;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tbControl <= RESET_WORD;
      tbPhase <= RESET_WORD;
      tbPeriod <= RESET_PERIOD;
      compareControl <= RESET_WORD;
      coarseShadow <= RESET_WORD;
      coarseActive <= RESET_WORD;
      coarseB <= RESET_WORD;
      fineShadow <= 8'h00;
      fineActive <= 8'h00;
      finePhase <= 8'h00;
      highResConfig <= 4'h0;
      protectOpen <= 1'b0;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
      response <= 2'b00;
      pending <= 1'b0;
      sawZero <= 1'b0;
      sawPeriod <= 1'b0;
    end
    else
    begin
      tbControl <= next_tbControl;
      tbPhase <= next_tbPhase;
      tbPeriod <= next_tbPeriod;
      compareControl <= next_compareControl;
      coarseShadow <= next_coarseShadow;
      coarseActive <= next_coarseActive;
      coarseB <= next_coarseB;
      fineShadow <= next_fineShadow;
      fineActive <= next_fineActive;
      finePhase <= next_finePhase;
      highResConfig <= next_highResConfig;
      protectOpen <= next_protectOpen;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      response <= next_response;
      pending <= next_pending;
      sawZero <= next_sawZero;
      sawPeriod <= next_sawPeriod;
    end
  end

  fine_edge_output #(
    .WIDTH(WIDTH)
  ) edgeInst (
    .clk(clk),
    .rst_n(rst_n),
    .count(count),
    .compare(coarseActive),
    .edgeSel(edgeMode),
    .fineValue(fineSel),
    .pwmOut(pwmOut),
    .riseStep(riseStep),
    .fallStep(fallStep)
  );
endmodule

//--- rtl/micro_edge_pkg.sv
package micro_edge_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_TB_CONTROL = 8'h00;
  localparam logic [7:0] IDX_TB_STATUS = 8'h01;
  localparam logic [7:0] IDX_FINE_PHASE = 8'h02;
  localparam logic [7:0] IDX_TB_PHASE = 8'h03;
  localparam logic [7:0] IDX_TB_COUNTER = 8'h04;
  localparam logic [7:0] IDX_TB_PERIOD = 8'h05;
  localparam logic [7:0] IDX_COMPARE_CONTROL = 8'h07;
  localparam logic [7:0] IDX_FINE_COMPARE_A = 8'h08;
  localparam logic [7:0] IDX_COARSE_COMPARE_A = 8'h09;
  localparam logic [7:0] IDX_COARSE_COMPARE_B = 8'h0a;
  localparam logic [7:0] IDX_HIGH_RES_CONFIG = 8'h20;
  localparam logic [7:0] IDX_PROTECT = 8'h21;
  localparam logic [7:0] IDX_ACTIVE_STATUS = 8'h22;
  // high_res_config fields
  localparam int CFG_LOAD_SEL_BIT = 3;
  localparam int CFG_SOURCE_BIT = 2;
  localparam int CFG_EDGE_LSB = 0;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h000f;
  // fine byte position
  localparam int FINE_LSB = 8;
  // compare_control field for the coarse load mode
  localparam int COARSE_LOAD_MODE_LSB = 0;
  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_PERIOD = 16'hffff;
  // time_base_control counter mode field
  localparam int CTRMODE_LSB = 0;
  // reserved for address window
  localparam logic [7:0] UNMAPPED_WORD = 8'hff;
  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_mode_t;
  typedef enum logic [1:0] {
    CLOAD_ZERO,
    CLOAD_PERIOD,
    CLOAD_EITHER,
    CLOAD_FREEZE
  } coarse_load_t;
endpackage

//--- rtl/time_base_counter.sv
`timescale 1ns/1ps
module time_base_counter
  import micro_edge_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic run, // counting enabled
  input wire logic [WIDTH-1:0] period, // period value
  input wire logic loadCount, // software write of counter
  input wire logic [WIDTH-1:0] loadValue, // value written
  output logic [WIDTH-1:0] count, // counter value
  output logic atZero, // counter equals zero
  output logic atPeriod // counter equals period
);
  logic [WIDTH-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (loadCount)
      next_count = loadValue;
    else if (run)
      next_count = (count >= period) ? '0 : count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count <= '0;
    else
      count <= next_count;
  end

  assign atZero = (count == '0);
  assign atPeriod = (count == period);
endmodule

//--- rtl/fine_edge_output.sv
`timescale 1ns/1ps
module fine_edge_output
  import micro_edge_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [WIDTH-1:0] count, // time-base count
  input wire logic [WIDTH-1:0] compare, // active coarse compare
  input wire logic [1:0] edgeSel, // adjusted edge select
  input wire logic [7:0] fineValue, // selected fine step
  output logic pwmOut, // coarse-timed channel output
  output logic [7:0] riseStep, // fine step on rising edge
  output logic [7:0] fallStep // fine step on falling edge
);
  logic next_pwmOut;
  logic [7:0] next_riseStep;
  logic [7:0] next_fallStep;
  logic fineOn;

  // zero step leaves fine edge idle
  assign fineOn = (fineValue != 8'h00);

  always_comb
  begin
    next_pwmOut = (count < compare);
    next_riseStep = 8'h00;
    next_fallStep = 8'h00;
    if (fineOn && edgeSel != EDGE_OFF)
    begin
      if (edgeSel == EDGE_RISE || edgeSel == EDGE_BOTH)
        next_riseStep = fineValue;
      if (edgeSel == EDGE_FALL || edgeSel == EDGE_BOTH)
        next_fallStep = fineValue;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwmOut <= 1'b0;
      riseStep <= 8'h00;
      fallStep <= 8'h00;
    end
    else
    begin
      pwmOut <= next_pwmOut;
      riseStep <= next_riseStep;
      fallStep <= next_fallStep;
    end
  end
endmodule

//--- verif/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  input wire logic clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clr, // clears captured values
  input wire logic pwmOut, // channel output
  input wire logic [7:0] riseStep, // fine rising step
  input wire logic [7:0] fallStep, // fine falling step
  output logic [7:0] seenRise, // last nonzero rising step
  output logic [7:0] seenFall, // last nonzero falling step
  output logic [15:0] pulseLen // last high time in cycles
);
  logic [15:0] highRun;
  logic lastOut;
  // stage only senses the output and its fine steps
  always_ff @(posedge clk)
  begin
    if (!rst_n || clr)
    begin
      seenRise <= 8'h00;
      seenFall <= 8'h00;
      pulseLen <= 16'h0000;
      highRun <= 16'h0000;
      lastOut <= 1'b0;
    end
    else
    begin
      lastOut <= pwmOut;
      highRun <= pwmOut ? highRun + 16'h0001 : 16'h0000;
      if (riseStep != 8'h00)
        seenRise <= riseStep;
      if (fallStep != 8'h00)
        seenFall <= fallStep;
      if (lastOut && !pwmOut)
        pulseLen <= highRun;
    end
  end
endmodule

//--- verif/micro_edge_pwm_config_chk.sv
`timescale 1ns/1ps
module micro_edge_pwm_config_chk
  import micro_edge_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [9:0] address, // byte address
  input wire logic read, // read strobe
  input wire logic write, // write strobe
  input wire logic [31:0] writedata, // write data
  input wire logic [3:0] byteenable, // byte enables
  input wire logic [31:0] readdata, // read data
  input wire logic waitrequest, // wait request
  input wire logic [1:0] response, // response code
  input wire logic [7:0] riseStep, // rising step
  input wire logic [7:0] fallStep // falling step
);
  logic done;
  logic [7:0] idx;
  logic protOpen;
  logic next_protOpen;
  logic [1:0] cfgEdge;
  logic [1:0] next_cfgEdge;
  assign done = !waitrequest && (read || write);
  assign idx = address[9:2];
  // mirror of the protect window and edge mode
  always_comb
  begin
    next_protOpen = protOpen;
    next_cfgEdge = cfgEdge;
    if (done && write && byteenable[0] && idx == IDX_PROTECT)
      next_protOpen = writedata[0];
    if (done && write && byteenable[0] && protOpen
        && idx == IDX_HIGH_RES_CONFIG)
      next_cfgEdge = writedata[1:0];
  end
  always_ff @(posedge clk)
  begin
    protOpen <= rst_n ? next_protOpen : 1'b0;
    cfgEdge <= rst_n ? next_cfgEdge : 2'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  answer_bound_a: assert property (
    (read || write) |-> ##[0:2] !waitrequest) else $error("no answer");
  pulse_once_a: assert property (
    !waitrequest |-> $past(read || write) ##1 waitrequest)
    else $error("bad answer pulse");
  rd_upper_zero_a: assert property (
    done && read |-> readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  unmapped_resp_a: assert property (
    done && read && idx == UNMAPPED_WORD
    |-> response == 2'h2 && readdata == 32'h0)
    else $error("unmapped read answered wrongly");
  fine_low_zero_a: assert property (
    done && read && (idx == IDX_FINE_COMPARE_A || idx == IDX_FINE_PHASE)
    |-> readdata[7:0] == 8'h00) else $error("fine low byte not zero");
  cfg_readback_a: assert property (
    done && read && idx == IDX_HIGH_RES_CONFIG
    |-> readdata[15:4] == 12'h000 && readdata[1:0] == cfgEdge)
    else $error("config read back wrong");
  edge_off_a: assert property (
    cfgEdge == 2'h0 && $past(cfgEdge, 3) == 2'h0
    |-> riseStep == 8'h00 && fallStep == 8'h00)
    else $error("fine step while disabled");
  rise_only_a: assert property (
    cfgEdge == EDGE_RISE && $past(cfgEdge, 3) == EDGE_RISE
    |-> fallStep == 8'h00) else $error("falling step in rise mode");
  cover property (done && read && idx == UNMAPPED_WORD);
  cover property (riseStep != 8'h00 && fallStep != 8'h00);
  cover property (done && write && !protOpen && idx == IDX_HIGH_RES_CONFIG);
endmodule
bind micro_edge_pwm_config micro_edge_pwm_config_chk chk_inst (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .riseStep(riseStep), .fallStep(fallStep));

//--- verif/micro_edge_pwm_config_tb.sv
`timescale 1ns/1ps
module micro_edge_pwm_config_tb;
  import micro_edge_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h3;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic pwmOut;
  logic [7:0] riseStep;
  logic [7:0] fallStep;
  logic clr = 1'b0;
  logic [7:0] seenRise;
  logic [7:0] seenFall;
  logic [15:0] pulseLen;
  logic [15:0] lastRd;
  logic [1:0] lastResp;
  int failures = 0;
  int checked = 0;
  logic [15:0] mCfg [5] = '{16'h0, 16'h1, 16'h2, 16'h7, 16'h3};
  logic [15:0] mFine [5] = '{16'h2a00, 16'h2a00, 16'h2a00, 16'h2a00, 16'h0};
  logic [7:0] mRise [5] = '{8'h00, 8'h2a, 8'h00, 8'h55, 8'h00};
  logic [7:0] mFall [5] = '{8'h00, 8'h00, 8'h2a, 8'h55, 8'h00};
  micro_edge_pwm_config #(.WIDTH(16)) micro_edge_pwm_config_inst (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .pwmOut(pwmOut), .riseStep(riseStep), .fallStep(fallStep));
  power_stage_model power_stage_model_inst (
    .clk(clk), .rst_n(rst_n), .clr(clr), .pwmOut(pwmOut),
    .riseStep(riseStep), .fallStep(fallStep), .seenRise(seenRise),
    .seenFall(seenFall), .pulseLen(pulseLen));
  always #10 clk = ~clk;
  task automatic final_report();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register access; waits for the answer edge
  task automatic bus(input logic wr, input logic [7:0] idx,
    input logic [15:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    writedata <= {16'h0000, wd};
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        failures++;
        final_report();
      end
      @(posedge clk);
    end
    lastRd = readdata[15:0];
    lastResp = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic act(input logic [15:0] cnt, input logic [15:0] exp);
    bus(1'b1, IDX_TB_COUNTER, cnt);
    bus(1'b0, IDX_ACTIVE_STATUS, 16'h0);
    chk(lastRd, exp);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, IDX_HIGH_RES_CONFIG, 16'h0);
    chk(lastRd, 16'h0000);
    bus(1'b0, IDX_FINE_COMPARE_A, 16'h0);
    chk(lastRd, 16'h0000);
    bus(1'b0, IDX_FINE_PHASE, 16'h0);
    chk(lastRd, 16'h0000);
    bus(1'b0, UNMAPPED_WORD, 16'h0);
    chk({14'h0, lastResp}, 16'h0002);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'h0003);
    bus(1'b0, IDX_HIGH_RES_CONFIG, 16'h0);
    chk(lastRd, 16'h0000);
    bus(1'b1, IDX_PROTECT, 16'h0001);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'hffff);
    bus(1'b0, IDX_HIGH_RES_CONFIG, 16'h0);
    chk(lastRd, 16'h000f);
    bus(1'b1, IDX_FINE_PHASE, 16'h5500);
    bus(1'b0, IDX_FINE_PHASE, 16'h0);
    chk(lastRd, 16'h5500);
    bus(1'b1, IDX_TB_PERIOD, 16'h000f);
    bus(1'b1, IDX_COARSE_COMPARE_A, 16'h0008);
    bus(1'b1, IDX_COMPARE_CONTROL, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, IDX_FINE_COMPARE_A, mFine[i]);
      bus(1'b0, IDX_FINE_COMPARE_A, 16'h0);
      chk(lastRd, mFine[i]);
      bus(1'b1, IDX_HIGH_RES_CONFIG, mCfg[i]);
      // let a counter zero move the new fine shadow into the active byte, except where mCfg selects the fine phase source
      repeat (20) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (40) @(posedge clk);
      chk({8'h00, seenRise}, {8'h00, mRise[i]});
      chk({8'h00, seenFall}, {8'h00, mFall[i]});
      chk(pulseLen, 16'h0008);
    end
    bus(1'b1, IDX_TB_CONTROL, 16'h0003);
    bus(1'b1, IDX_TB_COUNTER, 16'h0005);
    bus(1'b1, IDX_COMPARE_CONTROL, 16'h0001);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'h000b);
    bus(1'b1, IDX_FINE_COMPARE_A, 16'h3300);
    act(16'h0000, 16'h0000);
    act(16'h000f, 16'h3301);
    bus(1'b1, IDX_COMPARE_CONTROL, 16'h0000);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'h0003);
    bus(1'b1, IDX_FINE_COMPARE_A, 16'h4400);
    act(16'h000f, 16'h3301);
    act(16'h0000, 16'h4401);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'h000f);
    bus(1'b1, IDX_FINE_COMPARE_A, 16'h6600);
    act(16'h000f, 16'h4401);
    bus(1'b1, IDX_PROTECT, 16'h0000);
    bus(1'b1, IDX_HIGH_RES_CONFIG, 16'h0000);
    bus(1'b0, IDX_HIGH_RES_CONFIG, 16'h0);
    chk(lastRd, 16'h000f);
    final_report();
  end
endmodule
